// File: inc/overrange_pkg.sv
package overrange_pkg;
  typedef enum logic [1:0] {
    VAR_SINGLE,
    VAR_DUAL,
    VAR_QUAD
  } variant_t;
  typedef enum {
    SRC_FLAG,
    SRC_CLOCK,
    SRC_IDLE
  } c_src_t;
endpackage

// File: inc/overrange_regs.svh
`ifndef OVERRANGE_REGS_SVH
`define OVERRANGE_REGS_SVH
// ****************************************
// constants
// ****************************************
`define OVR_SAMPLE_W      9
`define OVR_PULSE_W       8
`define OVR_NUM_CH        4
`define OVR_CH_A          0
`define OVR_CH_B          1
`define OVR_CH_C          2
`define OVR_CFG_OFF       2'h0
`define OVR_CFG_COPY      2'h1
`define OVR_CFG_DIV2      2'h2
`define OVR_CFG_DIV4      2'h3
`define OVR_VAR_SINGLE    2'h0
`define OVR_VAR_DUAL      2'h1
`define OVR_VAR_QUAD      2'h2
`endif

// File: rtl/overrange_flag_clock_out_mux.sv
// Function
// - channel A output goes high when channel A exceeds threshold.
// - channel B output only on quad and dual variants, over threshold.
// - each asserted over-range flag stays high for at least the minimum pulse.
// - channel C flag only on quad variant, raised over threshold.
// - channel C carries divided or copied clock if enabled, synthesizer on and no power down.
// - straps both low with no register override, or override with register code 0, gives channel C the flag.
// - code 1 copy, code 2 divide by two, code 3 divide by four.
// - clock present from reset by straps alone with enable, no power down.
// - power down stops reference clock output and channel C clock.
`include "overrange_regs.svh"
module overrange_flag_clock_out_mux
  import overrange_pkg::*;
#(
  parameter int SW = `OVR_SAMPLE_W,
  parameter int PW = `OVR_PULSE_W
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  // configuration
  input  overrange_pkg::variant_t        variant,
  input  wire logic [SW-1:0]             overrange_threshold,
  input  wire logic [PW-1:0]             overrange_min_pulse,
  input  wire logic [1:0]                clock_output_select,
  input  wire logic                      clock_reg_override,
  input  wire logic [1:0]                clock_reg_select,
  input  wire logic                      synth_enable,
  input  wire logic                      power_down_input,
  input  wire logic                      ref_clock_in,
  // channel magnitudes
  input  wire logic [SW-1:0]             magnitude_a,
  input  wire logic [SW-1:0]             magnitude_b,
  input  wire logic [SW-1:0]             magnitude_c,
  // outputs
  output logic                           overrange_out_a,
  output logic                           overrange_out_b,
  output logic                           overrange_or_clock_out_c,
  output logic                           reference_clock_output
);
  import overrange_pkg::*;

  if (SW < 1 || PW < 1) begin : g_bad_width
    $error("bad width");
  end

  // ****************************************
  // over-range detectors
  // ****************************************
  logic [`OVR_NUM_CH-2:0] ch_en;
  logic [`OVR_NUM_CH-2:0] ch_flag;
  logic [SW-1:0]          mag [`OVR_NUM_CH-1];

  assign mag[`OVR_CH_A] = magnitude_a;
  assign mag[`OVR_CH_B] = magnitude_b;
  assign mag[`OVR_CH_C] = magnitude_c;
  assign ch_en[`OVR_CH_A] = 1'b1;
  assign ch_en[`OVR_CH_B] = (variant != VAR_SINGLE);
  assign ch_en[`OVR_CH_C] = (variant == VAR_QUAD);

  genvar g;
  generate
    for (g = 0; g < `OVR_NUM_CH - 1; g++) begin : g_ch
      overrange_hold #(.SW(SW), .PW(PW)) u_hold (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .enable    (ch_en[g]),
        .magnitude (mag[g]),
        .threshold (overrange_threshold),
        .min_pulse (overrange_min_pulse),
        .flag      (ch_flag[g])
      );
    end
  endgenerate

  // ****************************************
  // clock select and divider
  // ****************************************
  logic [1:0] sel;
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic       ref_prev_r;
  logic       ref_prev_nxt;
  logic       ref_rise;
  logic       clk_on;
  logic       div_clk;
  c_src_t     src;

  assign sel = clock_reg_override ? clock_reg_select
                                  : clock_output_select;
  assign clk_on = synth_enable && !power_down_input;
  assign ref_rise = ref_clock_in && !ref_prev_r;

  always_comb begin
    ref_prev_nxt = ref_clock_in;
    div_nxt = div_r;
    if (!clk_on) begin
      div_nxt = 2'h0;
    end else if (ref_rise) begin
      div_nxt = div_r + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_r      <= 2'h0;
      ref_prev_r <= 1'b0;
    end else if (ce) begin
      div_r      <= div_nxt;
      ref_prev_r <= ref_prev_nxt;
    end
  end

  always_comb begin
    if (sel == `OVR_CFG_OFF) begin
      src = SRC_FLAG;
    end else if (clk_on) begin
      src = SRC_CLOCK;
    end else begin
      src = SRC_IDLE;
    end
    case (sel)
      `OVR_CFG_COPY: div_clk = ref_clock_in;
      `OVR_CFG_DIV2: div_clk = div_r[0];
      `OVR_CFG_DIV4: div_clk = div_r[1];
      default:       div_clk = 1'b0;
    endcase
  end

  // ****************************************
  // outputs
  // ****************************************
  assign overrange_out_a = ch_flag[`OVR_CH_A];
  assign overrange_out_b = ch_flag[`OVR_CH_B];
  assign reference_clock_output = clk_on & ref_clock_in;

  always_comb begin
    case (src)
      SRC_FLAG:  overrange_or_clock_out_c = ch_flag[`OVR_CH_C];
      SRC_CLOCK: overrange_or_clock_out_c = div_clk;
      SRC_IDLE:  overrange_or_clock_out_c = 1'b0;
      default:   overrange_or_clock_out_c = 1'b0;
    endcase
  end

  // ****************************************
  // checks
  // ****************************************
  sequence over_a_s;
    ce && magnitude_a > overrange_threshold;
  endsequence

  flag_a_a: assert property (@(posedge clk) disable iff (!rstn)
    over_a_s |=> overrange_out_a) else $error("a flag missing");
  single_b_a: assert property (@(posedge clk) disable iff (!rstn)
    variant == VAR_SINGLE && $stable(variant) && !$past(overrange_out_b)
    |-> !overrange_out_b) else $error("b on single");
  hold_len_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && $rose(overrange_out_a) && overrange_min_pulse > 8'h1
    && $stable(overrange_min_pulse) ##0 ce[*1]
    |=> overrange_out_a || !ce) else $error("pulse short");
  c_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && variant == VAR_QUAD && magnitude_c > overrange_threshold
    && !clock_reg_override && clock_output_select == `OVR_CFG_OFF
    |=> clock_reg_override || clock_output_select != `OVR_CFG_OFF
    || overrange_or_clock_out_c) else $error("c not flag");
  c_copy_a: assert property (@(posedge clk) disable iff (!rstn)
    sel == `OVR_CFG_COPY && clk_on
    |-> overrange_or_clock_out_c == ref_clock_in) else $error("copy bad");
  pd_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    power_down_input |-> !reference_clock_output
    && (sel == `OVR_CFG_OFF || !overrange_or_clock_out_c))
    else $error("clock in pd");
  c_quad_a: assert property (@(posedge clk) disable iff (!rstn)
    variant == VAR_QUAD && ce && magnitude_c > overrange_threshold
    && $stable(variant) |=> ch_flag[`OVR_CH_C]) else $error("c missed");
  release_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !(magnitude_a > overrange_threshold) && overrange_out_a
    && overrange_min_pulse == 8'h0 |=> !overrange_out_a || !ce)
    else $error("a stuck");

  sequence over_b_s;
    ce && variant != VAR_SINGLE && magnitude_b > overrange_threshold;
  endsequence

  flag_b_a: assert property (@(posedge clk) disable iff (!rstn)
    over_b_s |=> overrange_out_b) else $error("b flag missing");
  ce_freeze_a: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(overrange_out_a) && $stable(overrange_out_b)
    && $stable(div_r)) else $error("ce ignored");

  // ****************************************
  // clock path checks
  // ****************************************
  sequence clk_out_s;
    ce && clk_on && sel != `OVR_CFG_OFF;
  endsequence

  sequence ref_edge_s;
    clk_out_s ##0 ref_rise;
  endsequence

  div_step_a: assert property (@(posedge clk) disable iff (!rstn)
    ref_edge_s |=> div_r == $past(div_r) + 2'h1)
    else $error("divider step");
  div_two_a: assert property (@(posedge clk) disable iff (!rstn)
    ref_edge_s ##0 sel == `OVR_CFG_DIV2
    |=> $changed(overrange_or_clock_out_c)
    || sel != `OVR_CFG_DIV2 || !clk_on) else $error("div2 bad");
  div_four_a: assert property (@(posedge clk) disable iff (!rstn)
    ref_edge_s ##0 sel == `OVR_CFG_DIV4
    |=> $changed(overrange_or_clock_out_c) == $past(div_r[0])
    || sel != `OVR_CFG_DIV4 || !clk_on) else $error("div4 bad");
  div_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !clk_on |=> div_r == 2'h0) else $error("divider kept");
  clk_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    !synth_enable |-> !reference_clock_output
    && (sel == `OVR_CFG_OFF || !overrange_or_clock_out_c))
    else $error("clock without synth");
  ref_copy_a: assert property (@(posedge clk) disable iff (!rstn)
    synth_enable && !power_down_input
    |-> reference_clock_output == ref_clock_in) else $error("ref bad");
endmodule

// File: rtl/overrange_hold.sv
`include "overrange_regs.svh"
// ****************************************
// per-channel threshold compare and stretch
// ****************************************
module overrange_hold #(
  parameter int SW = `OVR_SAMPLE_W,
  parameter int PW = `OVR_PULSE_W
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  // channel
  input  wire logic          enable,
  input  wire logic [SW-1:0] magnitude,
  input  wire logic [SW-1:0] threshold,
  input  wire logic [PW-1:0] min_pulse,
  output logic               flag
);
  logic          flag_r;
  logic          flag_nxt;
  logic [PW-1:0] cnt_r;
  logic [PW-1:0] cnt_nxt;
  logic          over;

  assign over = enable && (magnitude > threshold);
  assign flag = flag_r;

  always_comb begin
    flag_nxt = flag_r;
    cnt_nxt  = cnt_r;
    if (over) begin
      flag_nxt = 1'b1;
      cnt_nxt  = min_pulse;
    end else if (cnt_r > PW'(1)) begin
      cnt_nxt = cnt_r - PW'(1);
    end else begin
      flag_nxt = 1'b0;
      cnt_nxt  = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_r <= 1'b0;
      cnt_r  <= '0;
    end else if (ce) begin
      flag_r <= flag_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  hold_min_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && over |=> flag) else $error("flag missed");
endmodule

// File: test/overrange_flag_clock_out_mux_bench.sv
module overrange_flag_clock_out_mux_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import overrange_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic       clk = 1'b0, rstn = 1'b0, ce = 1'b1, ref_clk = 1'b0;
  logic       ovr_en = 1'b0, synth_en = 1'b1, pd = 1'b0, clk_mode = 1'b1;
  variant_t   variant = VAR_QUAD;
  logic [8:0] thr = 9'h000, mag_a = 9'h000, mag_b = 9'h000, mag_c = 9'h000;
  logic [7:0] min_pulse = 8'h00, w_a, w_b, w_c, r_c, r_r;
  logic [1:0] straps = 2'h1, reg_sel = 2'h0;
  logic       out_a, out_b, out_c, ref_out, d_a, d_b, d_c;
  logic [9:0] exp_q[$];
  integer     n_errors = 0, n_compared = 0, seed = 98735;

  overrange_flag_clock_out_mux i_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .variant(variant),
    .overrange_threshold(thr), .overrange_min_pulse(min_pulse),
    .clock_output_select(straps), .clock_reg_override(ovr_en),
    .clock_reg_select(reg_sel), .synth_enable(synth_en),
    .power_down_input(pd), .ref_clock_in(ref_clk),
    .magnitude_a(mag_a), .magnitude_b(mag_b), .magnitude_c(mag_c),
    .overrange_out_a(out_a), .overrange_out_b(out_b),
    .overrange_or_clock_out_c(out_c), .reference_clock_output(ref_out));
  pulse_monitor mon_a (.clk(clk), .rstn(rstn), .sig(out_a), .width(w_a),
    .done(d_a), .rises());
  pulse_monitor mon_b (.clk(clk), .rstn(rstn), .sig(out_b), .width(w_b),
    .done(d_b), .rises());
  pulse_monitor mon_c (.clk(clk), .rstn(rstn), .sig(out_c), .width(w_c),
    .done(d_c), .rises(r_c));
  pulse_monitor mon_r (.clk(clk), .rstn(rstn), .sig(ref_out), .width(),
    .done(), .rises(r_r));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string what, input logic [9:0] e, s);
    n_compared = n_compared + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic over_pulse(input int ch, input logic en);
    int k;
    logic [7:0] w;
    k = 1 + ($random(seed) & 3);
    min_pulse = 8'($random(seed) & 7);
    thr = 9'h010 + 9'($random(seed) & 255);
    w = 8'(k) + ((min_pulse == 8'h00) ? 8'h00 : min_pulse - 8'h01);
    if (en) exp_q.push_back({2'(ch), w});
    repeat (k) begin
      mag_a = thr + 9'(ch == 0);
      mag_b = thr + 9'(ch == 1);
      mag_c = thr + 9'(ch == 2);
      @(negedge clk);
    end
    {mag_a, mag_b, mag_c} = {3{thr}};
    repeat (16) @(negedge clk);
  endtask
  task automatic clk_case(input logic [1:0] s, input logic o,
      input logic [1:0] r, input logic e, p, input logic [7:0] ec, er);
    logic [7:0] c0, f0;
    {straps, ovr_en, reg_sel, synth_en, pd} = {s, o, r, e, p};
    repeat (12) @(negedge clk);
    {c0, f0} = {r_c, r_r};
    repeat (64) @(negedge clk);
    check("c rises", {2'h0, ec}, {2'h0, r_c - c0});
    check("ref rises", {2'h0, er}, {2'h0, r_r - f0});
  endtask
  // ****************************************
  // clocks, watcher, sequence
  // ****************************************
  initial forever #20 clk = ~clk;
  initial forever begin
    repeat (2) @(negedge clk);
    ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors = n_errors + 1;
    close_out();
  end
  always @(posedge clk) begin
    if (!clk_mode && (d_a | d_b | d_c)) begin
      check("flag pulse", exp_q.size() > 0 ? exp_q.pop_front() : 10'h3FF,
        d_a ? {2'h0, w_a} : d_b ? {2'h1, w_b} : {2'h2, w_c});
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    clk_case(2'h1, 1'b0, 2'h0, 1'b1, 1'b0, 8'h10, 8'h10);
    clk_case(2'h2, 1'b0, 2'h0, 1'b1, 1'b0, 8'h08, 8'h10);
    clk_case(2'h3, 1'b0, 2'h0, 1'b1, 1'b0, 8'h04, 8'h10);
    clk_case(2'h0, 1'b1, 2'h1, 1'b1, 1'b0, 8'h10, 8'h10);
    clk_case(2'h0, 1'b1, 2'h2, 1'b1, 1'b0, 8'h08, 8'h10);
    clk_case(2'h0, 1'b1, 2'h3, 1'b1, 1'b0, 8'h04, 8'h10);
    clk_case(2'h3, 1'b1, 2'h0, 1'b1, 1'b0, 8'h00, 8'h10);
    clk_case(2'h2, 1'b0, 2'h0, 1'b0, 1'b0, 8'h00, 8'h00);
    clk_case(2'h1, 1'b0, 2'h0, 1'b1, 1'b1, 8'h00, 8'h00);
    clk_case(2'h0, 1'b0, 2'h0, 1'b1, 1'b0, 8'h00, 8'h10);
    clk_mode = 1'b0;
    for (int v = 0; v < 6; v++) begin
      variant = variant_t'(v % 3);
      for (int ch = 0; ch < 3; ch++) begin
        over_pulse(ch, ch == 0 || (ch == 1 && variant != VAR_SINGLE) ||
          (ch == 2 && variant == VAR_QUAD));
      end
    end
    // one over sample, then five frozen cycles with ce low
    min_pulse = 8'h00;
    exp_q.push_back({2'h0, 8'h06});
    mag_a = thr + 9'h001;
    @(negedge clk);
    mag_a = thr;
    ce = 1'b0;
    repeat (5) @(negedge clk);
    ce = 1'b1;
    repeat (8) @(negedge clk);
    check("notes left", 10'h000, 10'(exp_q.size()));
    close_out();
  end
endmodule

// File: test/pulse_monitor.sv
// ****************************************
// downstream monitor of one output line
// ****************************************
module pulse_monitor (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // watched line and what was measured
  input  wire logic       sig,
  output logic [7:0]      width,
  output logic            done,
  output logic [7:0]      rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  // width of each high pulse, reported once as it ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      width <= 8'h00;
      done  <= 1'b0;
      rises <= 8'h00;
      last  <= 1'b0;
    end else begin
      last  <= sig;
      done  <= last & !sig;
      width <= sig ? (last ? width + 8'h01 : 8'h01) : width;
      rises <= rises + 8'(sig & !last);
    end
  end
endmodule
